//--- aux_conv_pkg.sv
// constants and types shared by the housekeeping converter control block
package aux_conv_pkg;

   // =====================================================
   // widths
   localparam int ADC_W     = 10;
   localparam int REG_W     = 16;
   localparam int ADDR_W    = 8;
   localparam int NUM_PINS  = 4;
   localparam int NUM_DAC   = 4;
   localparam int SRC_W     = 3;
   localparam int LEN_W     = 4;
   localparam int RATE_W    = 4;
   localparam int STEP_W    = 4;

   // =====================================================
   // register offsets
   localparam logic [ADDR_W-1:0] ADDR_ADC_MODE  = 8'ha7;
   localparam logic [ADDR_W-1:0] ADDR_DAC_CTRL  = 8'ha8;
   localparam logic [ADDR_W-1:0] ADDR_ADC1_RES  = 8'ha9;
   localparam logic [ADDR_W-1:0] ADDR_ADC2_RES  = 8'haa;
   localparam logic [ADDR_W-1:0] ADDR_THRESH    = 8'hb5;

   // =====================================================
   // adc mode register fields
   localparam int SRC1_LSB = 0;
   localparam int SRC2_LSB = 3;
   localparam int AVG1_BIT = 6;
   localparam int AVG2_BIT = 7;
   localparam logic [SRC_W-1:0] SRC_NONE = 3'h0;

   // =====================================================
   // dac control fields
   localparam int DAC_SEL_LSB  = 14;
   localparam int DAC_EN_BIT   = 13;
   localparam int DAC_RAMP_BIT = 12;
   localparam int DAC_DOWN_BIT = 11;
   localparam int RAMP_DAC     = 0;

   // =====================================================
   // threshold and result fields
   localparam int THR_CH_BIT = 15;
   localparam int THR_HI_BIT = 14;
   localparam int RES_HI_BIT = 15;
   localparam int RES_LO_BIT = 14;

   // =====================================================
   // averaging, timing
   localparam logic [LEN_W-1:0] AVG_LEN_RESET = 4'h0;
   localparam logic [LEN_W-1:0] AVG_LEN_MAX   = 4'h8;
   localparam int SAMPLE_PERIOD_NS = 250000;
   localparam int CLK_PERIOD_NS    = 4;
   localparam int SAMPLE_CYCLES    = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

   // =====================================================
   // ramp profile
   localparam int RAMP_STEPS = 16;
   localparam logic [STEP_W-1:0] STEP_LAST = 4'hf;
   typedef logic [ADC_W-1:0] profile_t [RAMP_STEPS];
   localparam profile_t RAISED_COSINE = '{
      10'h000, 10'h00b, 10'h02c, 10'h062, 10'h0a9, 10'h100, 10'h161, 10'h1ca,
      10'h235, 10'h29e, 10'h2ff, 10'h356, 10'h39d, 10'h3d3, 10'h3f4, 10'h3ff};

   typedef enum logic [1:0]
   {
      RAMP_IDLE = 2'b00,
      RAMP_RUN  = 2'b01,
      RAMP_HOLD = 2'b10
   } ramp_state_t;

   function automatic logic [LEN_W-1:0] clamp_len(input logic [LEN_W-1:0] l);
      clamp_len = (l > AVG_LEN_MAX) ? AVG_LEN_MAX : l;
   endfunction

endpackage

//--- adc_chan_if.sv
// carrier between the control top and one adc channel
`timescale 1ns/1ps
`default_nettype none
interface adc_chan_if;
   import aux_conv_pkg::*;
   logic               run;
   logic [ADC_W-1:0]   raw;
   logic               avg_en;
   logic [LEN_W-1:0]   avg_len;
   logic [ADC_W-1:0]   thr_hi;
   logic [ADC_W-1:0]   thr_lo;
   logic [ADC_W-1:0]   value;
   logic               above_hi;
   logic               below_lo;
   logic               event_pulse;
   modport ctrl (output run, raw, avg_en, avg_len, thr_hi, thr_lo,
                 input value, above_hi, below_lo, event_pulse);
   modport chan (input run, raw, avg_en, avg_len, thr_hi, thr_lo,
                 output value, above_hi, below_lo, event_pulse);
endinterface
`default_nettype wire

//--- adc_channel.sv
// one housekeeping adc channel: averaging and threshold crossing
`timescale 1ns/1ps
`default_nettype none
module adc_channel
   import aux_conv_pkg::*;
(
   // clock and reset
   input  wire logic clk,
   input  wire logic reset,
   // sample strobe
   input  wire logic sample_tick,
   // channel carrier
   adc_chan_if.chan  ch
);

   logic [ADC_W-1:0]        raw_reg;
   logic [ADC_W-1:0]        avg_reg;
   logic                    avg_on_reg;
   logic                    have_sample_reg;
   logic                    new_reg;
   logic [ADC_W-1:0]        prev_reg;
   logic signed [ADC_W:0]   diff;
   logic signed [ADC_W:0]   step;
   logic [ADC_W-1:0]        cur;

   // =====================================================
   // conversion
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         raw_reg         <= '0;
         have_sample_reg <= 1'b0;
      end
      else if (sample_tick && ch.run)
      begin
         raw_reg         <= ch.raw;
         have_sample_reg <= 1'b1;
      end
   end

   // =====================================================
   // rolling average: add 1/2^(len+1) of the error each sample
   assign diff = $signed({1'b0, raw_reg}) - $signed({1'b0, avg_reg});
   assign step = diff >>> (clamp_len(ch.avg_len) + 4'h1);

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         avg_reg    <= '0;
         avg_on_reg <= 1'b0;
      end
      else
      begin
         avg_on_reg <= ch.avg_en;
         if (ch.avg_en && !avg_on_reg)
            avg_reg <= have_sample_reg ? raw_reg : '0;
         else if (ch.avg_en && new_reg)
            avg_reg <= ADC_W'($signed({1'b0, avg_reg}) + step);
      end
   end

   // =====================================================
   // threshold crossing, once per new value
   assign cur = ch.avg_en ? avg_reg : raw_reg;

   always_ff @(posedge clk)
   begin
      if (reset)
         new_reg <= 1'b0;
      else
         new_reg <= sample_tick && ch.run;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         prev_reg       <= '0;
         ch.above_hi    <= 1'b0;
         ch.below_lo    <= 1'b0;
         ch.event_pulse <= 1'b0;
         ch.value       <= '0;
      end
      else
      begin
         ch.value       <= cur;
         ch.event_pulse <= 1'b0;
         if (new_reg)
         begin
            prev_reg    <= cur;
            ch.above_hi <= cur > ch.thr_hi;
            ch.below_lo <= cur < ch.thr_lo;
            // rising past high or falling past low only
            if ((prev_reg <= ch.thr_hi && cur > ch.thr_hi) ||
                (prev_reg >= ch.thr_lo && cur < ch.thr_lo))
               ch.event_pulse <= 1'b1;
         end
      end
   end

endmodule
`default_nettype wire

//--- ramp_profile_gen.sv
// profile sequencer for dac channel 1 in ramp mode
`timescale 1ns/1ps
`default_nettype none
module ramp_profile_gen
   import aux_conv_pkg::*;
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              reset,
   // control
   input  wire logic              base_tick,
   input  wire logic              start,
   input  wire logic              down,
   input  wire logic [RATE_W-1:0] rate,
   input  wire logic              tx_mode,
   // profile store write
   input  wire logic              store_write,
   input  wire logic [STEP_W-1:0] store_index,
   input  wire logic [ADC_W-1:0]  store_data,
   // output
   output var  logic [ADC_W-1:0]  level,
   output var  logic              busy
);

   profile_t          profile_reg;
   ramp_state_t       state_reg;
   logic [STEP_W-1:0] idx_reg;
   logic [RATE_W-1:0] div_reg;
   logic              down_reg;

   // =====================================================
   // profile store, raised cosine after reset
   always_ff @(posedge clk)
   begin
      if (reset)
         profile_reg <= RAISED_COSINE;
      else if (store_write)
         profile_reg[store_index] <= store_data;
   end

   // =====================================================
   // sequencer; leaving tx mid-ramp freezes it, hence glitch warning
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         state_reg <= RAMP_IDLE;
         idx_reg   <= '0;
         div_reg   <= '0;
         down_reg  <= 1'b0;
      end
      else
      begin
         unique case (state_reg)
            RAMP_IDLE, RAMP_HOLD:
               if (start && tx_mode)
               begin
                  state_reg <= RAMP_RUN;
                  down_reg  <= down;
                  idx_reg   <= down ? STEP_LAST : '0;
                  div_reg   <= rate;
               end
            RAMP_RUN:
               if (base_tick && tx_mode)
               begin
                  if (div_reg != '0)
                     div_reg <= div_reg - 4'h1;
                  else if ((down_reg && idx_reg == '0) ||
                           (!down_reg && idx_reg == STEP_LAST))
                     state_reg <= RAMP_HOLD;
                  else
                  begin
                     div_reg <= rate;
                     idx_reg <= down_reg ? idx_reg - 4'h1 : idx_reg + 4'h1;
                  end
               end
            default:
               state_reg <= RAMP_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         level <= '0;
         busy  <= 1'b0;
      end
      else
      begin
         level <= (state_reg == RAMP_IDLE) ? '0 : profile_reg[idx_reg];
         busy  <= state_reg == RAMP_RUN;
      end
   end

endmodule
`default_nettype wire

//--- aux_adc_dac_control.sv
// housekeeping adc and dac control with host register port
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - each adc channel selects any input pin
// - convert while source valid, stop on none
// - averaging switchable, length from store, resets zero
// - rolling average adds half, quarter, eighth...
// - averaging length useful only up to eight
// - accumulator starts from current value or zero
// - per channel thresholds, averaged or raw
// - event on rising high or falling low crossing
// - thresholds loaded through threshold register
// - result read gives status and value
// - one dac per control write, four writes
// - ramp bit makes dac1 play profile
// - profile defaults raised cosine, store rewritable
// - ramp only runs in transmit mode
// - powersave: enabled dac holds, dac1 in ramp mode keeps ramping, disabled zero
module aux_adc_dac_control
   import aux_conv_pkg::*;
#(
   parameter int SAMPLE_DIV = SAMPLE_CYCLES
)
(
   // clock and reset
   input  wire logic                       clk,
   input  wire logic                       reset,
   // host register port
   input  wire logic [ADDR_W-1:0]          reg_addr,
   input  wire logic [REG_W-1:0]           reg_wdata,
   input  wire logic                       reg_write,
   input  wire logic                       reg_read,
   output var  logic [REG_W-1:0]           reg_rdata,
   // device state
   input  wire logic                       bias_enable,
   input  wire logic                       tx_mode,
   input  wire logic                       powersave,
   // parameter store
   input  wire logic [LEN_W-1:0]           averaging_length,
   input  wire logic                       ramp_profile_store_write,
   input  wire logic [STEP_W-1:0]          ramp_profile_store_index,
   input  wire logic [ADC_W-1:0]           ramp_profile_store_data,
   // converter pins, digitised
   input  wire logic [NUM_PINS*ADC_W-1:0]  pin_sample,
   // outputs
   output var  logic [NUM_DAC*ADC_W-1:0]   housekeeping_dac_out,
   output var  logic                       threshold_irq,
   output var  logic                       ramp_busy
);

   localparam int DIV_W = $clog2(SAMPLE_DIV + 1);

   logic [REG_W-1:0]       adc_mode_reg;
   logic [ADC_W-1:0]       thr_hi_reg [2];
   logic [ADC_W-1:0]       thr_lo_reg [2];
   logic [ADC_W-1:0]       dac_level_reg [NUM_DAC];
   logic [NUM_DAC-1:0]     dac_en_reg;
   logic                   ramp_sel_reg;
   logic [DIV_W-1:0]       div_reg;
   logic                   tick_reg;
   logic                   ramp_start;
   logic [ADC_W-1:0]       ramp_level;
   logic                   ramp_run;
   logic [1:0]             dac_sel;
   logic                   wr_dac;
   adc_chan_if             ch1 ();
   adc_chan_if             ch2 ();

   // =====================================================
   // sample rate divider
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         div_reg  <= '0;
         tick_reg <= 1'b0;
      end
      else if (div_reg == DIV_W'(SAMPLE_DIV - 1))
      begin
         div_reg  <= '0;
         tick_reg <= 1'b1;
      end
      else
      begin
         div_reg  <= div_reg + 1'b1;
         tick_reg <= 1'b0;
      end
   end

   // =====================================================
   // write-only registers
   always_ff @(posedge clk)
   begin
      if (reset)
         adc_mode_reg <= '0;
      else if (reg_write && reg_addr == ADDR_ADC_MODE)
         adc_mode_reg <= reg_wdata;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         thr_hi_reg <= '{default: '1};
         thr_lo_reg <= '{default: '0};
      end
      else if (reg_write && reg_addr == ADDR_THRESH)
      begin
         if (reg_wdata[THR_HI_BIT])
            thr_hi_reg[reg_wdata[THR_CH_BIT]] <= reg_wdata[ADC_W-1:0];
         else
            thr_lo_reg[reg_wdata[THR_CH_BIT]] <= reg_wdata[ADC_W-1:0];
      end
   end

   // =====================================================
   // dac control: one channel per write
   assign wr_dac  = reg_write && reg_addr == ADDR_DAC_CTRL;
   assign dac_sel = reg_wdata[DAC_SEL_LSB +: 2];

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         dac_level_reg <= '{default: '0};
         dac_en_reg    <= '0;
         ramp_sel_reg  <= 1'b0;
      end
      else if (wr_dac)
      begin
         dac_level_reg[dac_sel] <= reg_wdata[ADC_W-1:0];
         dac_en_reg[dac_sel]    <= reg_wdata[DAC_EN_BIT];
         if (dac_sel == 2'(RAMP_DAC))
            ramp_sel_reg <= reg_wdata[DAC_RAMP_BIT];
      end
   end

   assign ramp_start = wr_dac && dac_sel == 2'(RAMP_DAC) &&
                       reg_wdata[DAC_RAMP_BIT];

   ramp_profile_gen ramp
   (
      .clk         (clk),
      .reset       (reset),
      .base_tick   (tick_reg),
      .start       (ramp_start),
      .down        (reg_wdata[DAC_DOWN_BIT]),
      .rate        (reg_wdata[RATE_W-1:0]),
      .tx_mode     (tx_mode),
      .store_write (ramp_profile_store_write),
      .store_index (ramp_profile_store_index),
      .store_data  (ramp_profile_store_data),
      .level       (ramp_level),
      .busy        (ramp_run)
   );

   // powersave has no effect: dac1 in ramp mode keeps following the profile, others hold; only the enable gates them
   always_ff @(posedge clk)
   begin
      if (reset)
         housekeeping_dac_out <= '0;
      else
         for (int i = 0; i < NUM_DAC; i++)
         begin
            if (!dac_en_reg[i])
               housekeeping_dac_out[i*ADC_W +: ADC_W] <= '0;
            else if (i == RAMP_DAC && ramp_sel_reg)
               housekeeping_dac_out[i*ADC_W +: ADC_W] <= ramp_level;
            else if (!powersave || i != RAMP_DAC || !ramp_sel_reg)
               housekeeping_dac_out[i*ADC_W +: ADC_W] <= dac_level_reg[i];
         end
   end

   // =====================================================
   // adc channels; no conversions without bias
   function automatic logic [ADC_W-1:0] pick_pin(input logic [SRC_W-1:0] s);
      pick_pin = '0;
      for (int p = 0; p < NUM_PINS; p++)
         if (s == SRC_W'(p + 1))
            pick_pin = pin_sample[p*ADC_W +: ADC_W];
   endfunction

   function automatic logic src_valid(input logic [SRC_W-1:0] s);
      src_valid = s != SRC_NONE && s <= SRC_W'(NUM_PINS);
   endfunction

   assign ch1.run     = bias_enable && src_valid(adc_mode_reg[SRC1_LSB +: SRC_W]);
   assign ch1.raw     = pick_pin(adc_mode_reg[SRC1_LSB +: SRC_W]);
   assign ch1.avg_en  = adc_mode_reg[AVG1_BIT];
   assign ch1.avg_len = averaging_length;
   assign ch1.thr_hi  = thr_hi_reg[0];
   assign ch1.thr_lo  = thr_lo_reg[0];
   assign ch2.run     = bias_enable && src_valid(adc_mode_reg[SRC2_LSB +: SRC_W]);
   assign ch2.raw     = pick_pin(adc_mode_reg[SRC2_LSB +: SRC_W]);
   assign ch2.avg_en  = adc_mode_reg[AVG2_BIT];
   assign ch2.avg_len = averaging_length;
   assign ch2.thr_hi  = thr_hi_reg[1];
   assign ch2.thr_lo  = thr_lo_reg[1];

   adc_channel adc1
   (
      .clk         (clk),
      .reset       (reset),
      .sample_tick (tick_reg),
      .ch          (ch1.chan)
   );

   adc_channel adc2
   (
      .clk         (clk),
      .reset       (reset),
      .sample_tick (tick_reg),
      .ch          (ch2.chan)
   );

   // =====================================================
   // readback and event output
   function automatic logic [REG_W-1:0] result_word(input logic hi,
                                                    input logic lo,
                                                    input logic [ADC_W-1:0] v);
      result_word             = '0;
      result_word[RES_HI_BIT] = hi;
      result_word[RES_LO_BIT] = lo;
      result_word[ADC_W-1:0]  = v;
   endfunction

   always_ff @(posedge clk)
   begin
      if (reset)
         reg_rdata <= '0;
      else if (reg_read)
      begin
         if (reg_addr == ADDR_ADC1_RES)
            reg_rdata <= result_word(ch1.above_hi, ch1.below_lo, ch1.value);
         else if (reg_addr == ADDR_ADC2_RES)
            reg_rdata <= result_word(ch2.above_hi, ch2.below_lo, ch2.value);
         else
            reg_rdata <= '0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         threshold_irq <= 1'b0;
         ramp_busy     <= 1'b0;
      end
      else
      begin
         threshold_irq <= ch1.event_pulse || ch2.event_pulse;
         ramp_busy     <= ramp_run;
      end
   end

endmodule
`default_nettype wire

//--- aux_conv_chk.sv
// port checker for the housekeeping converter control block
`timescale 1ns/1ps
`default_nettype none
module aux_conv_chk
   import aux_conv_pkg::*;
#(
   parameter int SAMPLE_DIV = SAMPLE_CYCLES
)
(
   // clock and reset
   input wire logic                     clk,
   input wire logic                     reset,
   // host port
   input wire logic [ADDR_W-1:0]        reg_addr,
   input wire logic [REG_W-1:0]         reg_wdata,
   input wire logic                     reg_write,
   input wire logic                     reg_read,
   input wire logic [REG_W-1:0]         reg_rdata,
   input wire logic                     tx_mode,
   // outputs
   input wire logic [NUM_DAC*ADC_W-1:0] housekeeping_dac_out,
   input wire logic                     threshold_irq,
   input wire logic                     ramp_busy
);
   // =====================================================
   // helpers
   logic dac_wr;
   logic ramp_wr;
   logic res_rd;
   logic unm_rd;
   assign dac_wr = reg_write && reg_addr == ADDR_DAC_CTRL;
   assign ramp_wr = dac_wr && reg_wdata[DAC_RAMP_BIT]
                    && reg_wdata[15:14] == 2'b00;
   assign res_rd = reg_read
                   && (reg_addr == ADDR_ADC1_RES || reg_addr == ADDR_ADC2_RES);
   assign unm_rd = reg_read && !res_rd;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   // =====================================================
   // assertions
   AST_RESET_OUT: assert property (disable iff (1'b0) reset |=>
      housekeeping_dac_out == '0 && !threshold_irq && !ramp_busy
      && reg_rdata == '0)
      else $error("reset output");
   AST_RDATA_HOLD: assert property (!reg_read |=> $stable(reg_rdata))
      else $error("rdata moved");
   AST_RES_PAD: assert property (res_rd |=> reg_rdata[13:10] == 4'h0)
      else $error("pad bits");
   AST_UNMAPPED: assert property (unm_rd |=> reg_rdata == 16'h0000)
      else $error("unmapped read");
   // spacing assumes SAMPLE_DIV of at least 8
   AST_IRQ_ONCE: assert property (threshold_irq |=> (!threshold_irq)[*7])
      else $error("event repeat");
   AST_DAC_ONE: assert property (!$past(reset) |-> $onehot0({
      $changed(housekeeping_dac_out[9:0]),
      $changed(housekeeping_dac_out[19:10]),
      $changed(housekeeping_dac_out[29:20]),
      $changed(housekeeping_dac_out[39:30])}))
      else $error("two dacs moved");
   AST_DAC_CAUSE: assert property ($changed(housekeeping_dac_out[39:10])
      |-> $past(dac_wr) || $past(dac_wr, 2) || $past(reset))
      else $error("dac moved unasked");
   // state, busy and output flops: three edges to the port
   AST_RAMP_START: assert property (ramp_wr && tx_mode |-> ##3 ramp_busy)
      else $error("no ramp start");
   AST_RAMP_NO_TX: assert property
      (ramp_wr && !tx_mode && !ramp_busy ##1 !tx_mode |=> !ramp_busy)
      else $error("ramp outside tx");
   AST_RAMP_FREEZE: assert property
      ((!tx_mode && !dac_wr)[*4] |=> $stable(housekeeping_dac_out[9:0]))
      else $error("dac1 moved outside tx");

   // =====================================================
   // covers
   cover property (ramp_busy ##1 !ramp_busy);
   cover property (threshold_irq);
   cover property (res_rd ##1 reg_rdata[15]);
endmodule
`default_nettype wire

//--- aux_pin_model.sv
// behavioural model of the four digitised analogue input pins
`timescale 1ns/1ps
`default_nettype none
module aux_pin_model
   import aux_conv_pkg::*;
(
   // clock
   input  wire logic                      clk,
   // digitised pin levels
   output var  logic [NUM_PINS*ADC_W-1:0] pin_sample
);
   logic [ADC_W-1:0] level [NUM_PINS];

   // =====================================================
   // level setting
   task automatic set_pin(input int p, input logic [ADC_W-1:0] v);
      level[p] = v;
   endtask

   initial
   begin
      level = '{default: '0};
      pin_sample = '0;
   end

   // levels move on the falling edge, clear of sampling
   always @(negedge clk)
      for (int p = 0; p < NUM_PINS; p++)
         pin_sample[p*ADC_W +: ADC_W] <= level[p];
endmodule
`default_nettype wire

//--- tb_aux_adc_dac_control.sv
// self-checking bench for the housekeeping converter control block
`timescale 1ns/1ps
`default_nettype none
module tb_aux_adc_dac_control;
   import aux_conv_pkg::*;
   localparam int SD = 8;
   logic              clk = 1'b0;
   logic              reset = 1'b1;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [REG_W-1:0]  reg_wdata = '0;
   logic              reg_write = 1'b0;
   logic              reg_read = 1'b0;
   logic [REG_W-1:0]  reg_rdata;
   logic              bias_enable = 1'b1;
   logic              tx_mode = 1'b0;
   logic              powersave = 1'b0;
   logic [LEN_W-1:0]  averaging_length = '0;
   logic              st_wr = 1'b0;
   logic [STEP_W-1:0] st_idx = '0;
   logic [ADC_W-1:0]  st_dat = '0;
   logic [39:0]       pin_sample;
   logic [39:0]       housekeeping_dac_out;
   logic              threshold_irq;
   logic              ramp_busy;
   int                bad_count = 0;
   int                check_count = 0;
   int                cyc = 0;
   int                irq_n = 0;

   aux_pin_model pins (.clk(clk), .pin_sample(pin_sample));

   aux_adc_dac_control #(.SAMPLE_DIV(SD)) dut (
      .clk(clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .bias_enable(bias_enable), .tx_mode(tx_mode),
      .powersave(powersave), .averaging_length(averaging_length),
      .ramp_profile_store_write(st_wr), .ramp_profile_store_index(st_idx),
      .ramp_profile_store_data(st_dat), .pin_sample(pin_sample),
      .housekeeping_dac_out(housekeeping_dac_out),
      .threshold_irq(threshold_irq), .ramp_busy(ramp_busy));

   // =====================================================
   // clock, timeout, event count
   always #2 clk = ~clk;

   always @(posedge clk)
   begin
      cyc++;
      if (threshold_irq === 1'b1)
         irq_n++;
      if (cyc == 40000)
      begin
         bad_count++;
         report_and_stop();
      end
   end

   // =====================================================
   // tasks
   task automatic chk_vec(input string n, input logic [39:0] e,
                          input logic [39:0] g);
      check_count++;
      if (g !== e)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_write = 1'b1;
      @(negedge clk);
      reg_write = 1'b0;
      @(negedge clk);
   endtask

   task automatic rd_chk(input string n, input logic [ADDR_W-1:0] a,
                         input logic [REG_W-1:0] e);
      reg_addr = a;
      reg_read = 1'b1;
      @(negedge clk);
      reg_read = 1'b0;
      @(negedge clk);
      chk_vec(n, 40'(e), 40'(reg_rdata));
   endtask

   task automatic ticks(input int n);
      repeat (n * SD) @(negedge clk);
   endtask

   task automatic wait_busy(input logic v);
      int n = 0;
      while (ramp_busy !== v && n < 2000)
      begin
         @(negedge clk);
         n++;
      end
      chk_vec("ramp busy wait", 40'h1, 40'(n < 2000));
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   function automatic logic [ADC_W-1:0] pl(input int p);
      pl = 10'h0c3 + 10'(p * 200);
   endfunction

   // =====================================================
   // main sequence
   logic [ADC_W-1:0] tl [4] = '{10'h250, 10'h150, 10'h050, 10'h150};
   logic [REG_W-1:0] tr [4] = '{16'h8250, 16'h0150, 16'h4050, 16'h0150};
   int               ti [4] = '{1, 0, 1, 0};

   initial
   begin
      int sh;
      int n0;
      logic [ADC_W-1:0] lv;
      logic [39:0] exp_dac;
      repeat (12) @(negedge clk);
      reset = 1'b0;
      @(negedge clk);
      rd_chk("unmapped", 8'h00, 16'h0000);
      rd_chk("ch1 idle", ADDR_ADC1_RES, 16'h0000);
      for (int p = 0; p < 4; p++)
         pins.set_pin(p, pl(p));
      for (int s = 1; s <= 4; s++)
      begin
         wr(ADDR_ADC_MODE, 16'((s % 4 + 1) << SRC2_LSB | s));
         ticks(3);
         rd_chk("ch1 raw", ADDR_ADC1_RES, 16'(pl(s - 1)));
         rd_chk("ch2 raw", ADDR_ADC2_RES, 16'(pl(s % 4)));
      end
      wr(ADDR_ADC_MODE, 16'h0000);
      pins.set_pin(3, 10'h001);
      ticks(3);
      rd_chk("ch1 stopped", ADDR_ADC1_RES, 16'(pl(3)));
      wr(ADDR_ADC_MODE, 16'h0001);
      ticks(3);
      bias_enable = 1'b0;
      pins.set_pin(0, 10'h2aa);
      ticks(3);
      rd_chk("ch1 no bias", ADDR_ADC1_RES, 16'(pl(0)));
      bias_enable = 1'b1;
      for (int k = 0; k < 4; k++)
      begin
         sh = (k < 3) ? k : 8;
         averaging_length = (k < 3) ? 4'(k) : 4'hf;
         pins.set_pin(0, 10'h100);
         wr(ADDR_ADC_MODE, 16'h0001);
         ticks(3);
         wr(ADDR_ADC_MODE, 16'h0041);
         ticks(4);
         rd_chk("avg start", ADDR_ADC1_RES, 16'h0100);
         pins.set_pin(0, 10'h3ff);
         ticks(600);
         rd_chk("avg settle", ADDR_ADC1_RES,
                16'h03ff - 16'((2 << sh) - 1));
      end
      wr(ADDR_ADC_MODE, 16'h0010);
      wr(ADDR_THRESH, 16'hc200);
      wr(ADDR_THRESH, 16'h8100);
      pins.set_pin(1, 10'h150);
      ticks(3);
      rd_chk("ch2 between", ADDR_ADC2_RES, 16'h0150);
      for (int i = 0; i < 4; i++)
      begin
         n0 = irq_n;
         pins.set_pin(1, tl[i]);
         ticks(3);
         chk_vec("threshold events", 40'(ti[i]), 40'(irq_n - n0));
         rd_chk("ch2 status", ADDR_ADC2_RES, tr[i]);
      end
      exp_dac = '0;
      for (int i = 0; i < 4; i++)
      begin
         lv = {i[1:0], 8'h5a};
         wr(ADDR_DAC_CTRL, {i[1:0], 1'b1, 3'b000, lv});
         exp_dac[i*ADC_W +: ADC_W] = lv;
         chk_vec("dac one write", exp_dac, housekeeping_dac_out);
      end
      wr(ADDR_DAC_CTRL, 16'h8000);
      exp_dac[29:20] = '0;
      chk_vec("dac disabled", exp_dac, housekeeping_dac_out);
      powersave = 1'b1;
      repeat (5) @(negedge clk);
      chk_vec("dac powersave", exp_dac, housekeeping_dac_out);
      powersave = 1'b0;
      tx_mode = 1'b1;
      wr(ADDR_DAC_CTRL, 16'h3000);
      wait_busy(1'b1);
      wait_busy(1'b0);
      repeat (3) @(negedge clk);
      chk_vec("ramp end", 40'(RAISED_COSINE[STEP_LAST]),
              40'(housekeeping_dac_out[9:0]));
      st_idx = STEP_LAST;
      st_dat = 10'h2aa;
      st_wr = 1'b1;
      @(negedge clk);
      st_wr = 1'b0;
      wr(ADDR_DAC_CTRL, 16'h3001);
      wait_busy(1'b1);
      wait_busy(1'b0);
      repeat (3) @(negedge clk);
      chk_vec("ramp user end", 40'h2aa,
              40'(housekeeping_dac_out[9:0]));
      tx_mode = 1'b0;
      wr(ADDR_DAC_CTRL, 16'h3000);
      repeat (20) @(negedge clk);
      chk_vec("ramp outside tx", 40'h0, 40'(ramp_busy));
      report_and_stop();
   end
endmodule

bind aux_adc_dac_control aux_conv_chk #(.SAMPLE_DIV(SAMPLE_DIV)) u_chk (
   .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
   .tx_mode(tx_mode), .housekeeping_dac_out(housekeeping_dac_out),
   .threshold_irq(threshold_irq), .ramp_busy(ramp_busy));
`default_nettype wire
